/* hw/ext_bus_pkg.sv */
package ext_bus_pkg;
	localparam int WAIT_FIELD_W = 4;
	localparam logic [3:0] WAIT_FIELD_RESET = 4'h0;
	localparam int AREA_COUNT = 8;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam logic [7:0] AREA_SEL_IDLE = 8'hFF;
	localparam int RELEASE_MIN_STATES = 3;
	localparam logic [1:0] REQ_CNT_RELEASE = 2'h2;
	localparam int RELEASE_HIGH_SAMPLES = 2;
	localparam logic [4:0] WAIT_CNT_ONE = 5'h01;
endpackage : ext_bus_pkg

/* hw/wait_seq_if.sv */
`timescale 1ns/1ps
interface wait_seq_if;
	logic start;
	logic [3:0] wait_field;
	logic wait_request_n;
	logic in_second;
	logic in_wait;
	logic in_final;
	logic done;
	modport ctrl (output start, output wait_field, output wait_request_n,
		input in_second, input in_wait, input in_final, input done);
	modport seq (input start, input wait_field, input wait_request_n,
		output in_second, output in_wait, output in_final, output done);
endinterface : wait_seq_if

/* hw/access_wait_seq.sv */
`timescale 1ns/1ps
module access_wait_seq
	import ext_bus_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	wait_seq_if.seq ws
);
	typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_WAIT, ST_FINAL} seq_state_t;
	seq_state_t state, next_state;
	logic [4:0] wait_left, next_wait_left;

	always_comb begin
		next_state = state;
		next_wait_left = wait_left;
		case (state)
			ST_IDLE: begin
				if (ws.start) begin
					next_state = ST_SECOND;
				end
			end
			ST_SECOND: begin
				// Field value plus one gives the wait count, so zero still yields one wait.
				next_wait_left = {1'b0, ws.wait_field} + WAIT_CNT_ONE;
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (wait_left > WAIT_CNT_ONE) begin
					next_wait_left = wait_left - WAIT_CNT_ONE;
				end else if (!ws.wait_request_n) begin
					// Pin wait extends only after the programmed waits have run out.
					next_wait_left = wait_left;
				end else begin
					next_state = ST_FINAL;
				end
			end
			ST_FINAL: begin
				next_state = ws.start ? ST_SECOND : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			wait_left <= 5'h00;
		end else begin
			state <= next_state;
			wait_left <= next_wait_left;
		end
	end

	assign ws.in_second = (state == ST_SECOND);
	assign ws.in_wait = (state == ST_WAIT);
	assign ws.in_final = (state == ST_FINAL);
	assign ws.done = (state == ST_FINAL);
endmodule : access_wait_seq

/* hw/ext_bus_wait_and_arbiter.sv */
// How it works
// - A wait field of zero still gives one inserted wait state.
// - Back-to-back sequential reads keep the read strobe low throughout.
// - Programmed waits of one to sixteen sit between second and final states.
// - Pin wait starts after programmed waits; a low request adds a wait.
// - While the wait request stays low, waits continue; final follows high.
// - The external master wins over the processor when both request.
// - The granted requester keeps the bus until its grant is withdrawn.
// - Requests are sampled always; handover happens only at release points.
// - Processor hands over only at cycle ends, never inside a paired access.
// - During internal processor work the bus is released once the running access ends.
// - In power-down no new access starts; the bus is released once any running access ends.
// - Released bus holds all outputs and drives the grant low.
// - The request is sampled every rising clock edge.
// - Two consecutive high samples end the release and raise the grant.
// - At least three states pass from request low to release.
// - Wait count equals field value plus one.
// - Areas using the wait request pin are set to two or more waits.
`timescale 1ns/1ps
module ext_bus_wait_and_arbiter
	import ext_bus_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Processor access request and completion
	input wire logic cpu_req_i,
	input wire logic cpu_write_i,
	input wire logic cpu_seq_i,
	input wire logic cpu_pair_first_i,
	input wire logic [1:0] cpu_lanes_i,
	input wire logic [2:0] cpu_area_i,
	input wire logic [ADDR_W-1:0] cpu_addr_i,
	input wire logic [DATA_W-1:0] cpu_wdata_i,
	input wire logic [WAIT_FIELD_W-1:0] program_wait_count_i,
	input wire logic cpu_internal_op_i,
	input wire logic cpu_power_down_i,
	output logic cpu_done_o,
	output logic [DATA_W-1:0] cpu_rdata_o,
	// External bus pins
	input wire logic wait_request_n_i,
	input wire logic ext_master_req_n_i,
	input wire logic [DATA_W-1:0] data_in_i,
	output logic ext_master_grant_n_o,
	output logic address_strobe_n_o,
	output logic read_strobe_n_o,
	output logic upper_write_strobe_n_o,
	output logic lower_write_strobe_n_o,
	output logic [AREA_COUNT-1:0] area_select_n_o,
	output logic [ADDR_W-1:0] address_o,
	output logic [DATA_W-1:0] data_out_o,
	output logic data_oe_o
);
	typedef enum logic [1:0] {OWN_CPU, OWN_HANDOVER, OWN_EXT} owner_t;
	owner_t owner, next_owner;
	logic [1:0] req_cnt, next_req_cnt;
	logic high_seen, next_high_seen;
	logic cycle_active, next_cycle_active;
	logic pair_lock, next_pair_lock;
	logic grant_n, next_grant_n;
	logic as_n, next_as_n;
	logic rd_n, next_rd_n;
	logic [1:0] wr_n, next_wr_n;
	logic [AREA_COUNT-1:0] cs_n, next_cs_n;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] dout, next_dout;
	logic doe, next_doe;
	logic done, next_done;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic cur_write, next_cur_write;
	logic cur_seq, next_cur_seq;
	logic start_ok;

	wait_seq_if ws();

	access_wait_seq u_seq (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.ws(ws)
	);

	function automatic logic [AREA_COUNT-1:0] area_decode(input logic [2:0] area);
		area_decode = AREA_SEL_IDLE;
		area_decode[area] = 1'b0;
	endfunction : area_decode

	// A new processor access starts only while the processor keeps the bus.
	assign start_ok = (owner == OWN_CPU) && cpu_req_i && !cpu_power_down_i
		&& (!cycle_active || ws.in_final);
	assign ws.start = start_ok && !(req_cnt == REQ_CNT_RELEASE && !pair_lock);
	assign ws.wait_field = program_wait_count_i;
	assign ws.wait_request_n = wait_request_n_i;

	always_comb begin
		next_owner = owner;
		next_req_cnt = req_cnt;
		next_high_seen = high_seen;
		next_cycle_active = cycle_active;
		next_pair_lock = pair_lock;
		next_grant_n = grant_n;
		next_as_n = as_n;
		next_rd_n = rd_n;
		next_wr_n = wr_n;
		next_cs_n = cs_n;
		next_addr = addr;
		next_dout = dout;
		next_doe = doe;
		next_done = 1'b0;
		next_rdata = rdata;
		next_cur_write = cur_write;
		next_cur_seq = cur_seq;
		// The request is sampled on every edge and counted toward the release delay.
		if (ext_master_req_n_i) begin
			next_req_cnt = 2'h0;
		end else if (req_cnt != REQ_CNT_RELEASE) begin
			next_req_cnt = req_cnt + 2'h1;
		end
		if (ws.in_final) begin
			next_done = 1'b1;
			next_cycle_active = 1'b0;
			if (!cur_write) begin
				next_rdata = data_in_i;
			end
			next_as_n = 1'b1;
			next_wr_n = 2'b11;
			if (!(cpu_seq_i && !cpu_write_i && ws.start && cur_seq)) begin
				next_rd_n = 1'b1;
			end
			next_cs_n = AREA_SEL_IDLE;
			next_doe = 1'b0;
		end
		if (ws.start) begin
			next_cycle_active = 1'b1;
			next_pair_lock = cpu_pair_first_i;
			next_cur_write = cpu_write_i;
			next_cur_seq = cpu_seq_i;
			next_addr = cpu_addr_i;
			next_as_n = 1'b0;
			next_cs_n = area_decode(cpu_area_i);
			next_rd_n = cpu_write_i;
			next_wr_n = cpu_write_i ? ~cpu_lanes_i : 2'b11;
			next_dout = cpu_wdata_i;
			next_doe = cpu_write_i;
		end else if (ws.in_final) begin
			next_pair_lock = 1'b0;
		end
		case (owner)
			OWN_CPU: begin
				// Internal work or power-down moves to handover before the final state; the grant still waits for the access to end.
				if (req_cnt == REQ_CNT_RELEASE && !pair_lock &&
					(!cycle_active || ws.in_final ||
					cpu_internal_op_i || cpu_power_down_i)) begin
					next_owner = OWN_HANDOVER;
				end
			end
			OWN_HANDOVER: begin
				if (!cycle_active) begin
					next_owner = OWN_EXT;
					next_grant_n = 1'b0;
					next_high_seen = 1'b0;
					next_doe = 1'b0;
				end
			end
			OWN_EXT: begin
				// Pins keep their held values; only two high samples end the release.
				if (ext_master_req_n_i) begin
					next_high_seen = 1'b1;
					if (high_seen) begin
						next_owner = OWN_CPU;
						next_grant_n = 1'b1;
					end
				end else begin
					next_high_seen = 1'b0;
				end
			end
			default: begin
				next_owner = OWN_CPU;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			owner <= OWN_CPU;
			req_cnt <= 2'h0;
			high_seen <= 1'b0;
			cycle_active <= 1'b0;
			pair_lock <= 1'b0;
			grant_n <= 1'b1;
			as_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 2'b11;
			cs_n <= AREA_SEL_IDLE;
			addr <= '0;
			dout <= '0;
			doe <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
			cur_write <= 1'b0;
			cur_seq <= 1'b0;
		end else begin
			owner <= next_owner;
			req_cnt <= next_req_cnt;
			high_seen <= next_high_seen;
			cycle_active <= next_cycle_active;
			pair_lock <= next_pair_lock;
			grant_n <= next_grant_n;
			as_n <= next_as_n;
			rd_n <= next_rd_n;
			wr_n <= next_wr_n;
			cs_n <= next_cs_n;
			addr <= next_addr;
			dout <= next_dout;
			doe <= next_doe;
			done <= next_done;
			rdata <= next_rdata;
			cur_write <= next_cur_write;
			cur_seq <= next_cur_seq;
		end
	end

	assign ext_master_grant_n_o = grant_n;
	assign address_strobe_n_o = as_n;
	assign read_strobe_n_o = rd_n;
	assign upper_write_strobe_n_o = wr_n[1];
	assign lower_write_strobe_n_o = wr_n[0];
	assign area_select_n_o = cs_n;
	assign address_o = addr;
	assign data_out_o = dout;
	assign data_oe_o = doe;
	assign cpu_done_o = done;
	assign cpu_rdata_o = rdata;
endmodule : ext_bus_wait_and_arbiter

/* verif/ext_mem_model.sv */
`timescale 1ns/1ps
module ext_mem_model
	import ext_bus_pkg::*;
(
	// Bus side
	input wire logic ref_clk_i,
	input wire logic read_strobe_n_i,
	input wire logic [ADDR_W-1:0] address_i,
	// Test control
	input wire logic stall_i,
	// Answers
	output logic wait_request_n_o,
	output logic [DATA_W-1:0] data_o
);
	logic [DATA_W-1:0] last = 16'h0000;
	// The wait line has a pull-up, so it sits high unless a stall is commanded.
	assign wait_request_n_o = !stall_i;
	// Outside a read the data bus flips every cycle, so stale data never passes as valid.
	always_ff @(posedge ref_clk_i) begin
		if (!read_strobe_n_i) begin
			last <= address_i[DATA_W-1:0] ^ 16'hA5C3;
		end else begin
			last <= ~last;
		end
	end
	assign data_o = last;
endmodule : ext_mem_model

/* verif/ext_bus_wait_and_arbiter_chk.sv */
`timescale 1ns/1ps
module ext_bus_wait_and_arbiter_chk
	import ext_bus_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Watched pins
	input wire logic wait_request_n_i,
	input wire logic ext_master_req_n_i,
	input wire logic cpu_done_o,
	input wire logic ext_master_grant_n_o,
	input wire logic address_strobe_n_o,
	input wire logic read_strobe_n_o,
	input wire logic [AREA_COUNT-1:0] area_select_n_o,
	input wire logic [ADDR_W-1:0] address_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	grant_stays_a: assert property (!ext_master_grant_n_o && !ext_master_req_n_i |=>
		!ext_master_grant_n_o) else $error("grant withdrawn under request");
	grant_end_a: assert property (ext_master_req_n_i [*2] |-> ##[0:2]
		ext_master_grant_n_o) else $error("grant not restored");
	release_min_a: assert property ($fell(ext_master_grant_n_o) |->
		!$past(ext_master_req_n_i) && !$past(ext_master_req_n_i, 2)
		&& !$past(ext_master_req_n_i, 3)) else $error("release too early");
	no_stray_grant_a: assert property (ext_master_grant_n_o && ext_master_req_n_i |=>
		ext_master_grant_n_o) else $error("grant without request");
	released_idle_a: assert property (!ext_master_grant_n_o |-> address_strobe_n_o
		&& read_strobe_n_o && area_select_n_o == AREA_SEL_IDLE) else $error("bus active");
	addr_held_a: assert property (!ext_master_grant_n_o && !$past(ext_master_grant_n_o) |->
		$stable(address_o)) else $error("address moved while released");
	no_cpu_release_a: assert property (!ext_master_grant_n_o [*2] |-> !cpu_done_o)
		else $error("processor access during release");
	wait_stretch_a: assert property (!wait_request_n_i [*2] |-> ##1 !cpu_done_o)
		else $error("access ended under wait");
endmodule : ext_bus_wait_and_arbiter_chk

bind ext_bus_wait_and_arbiter ext_bus_wait_and_arbiter_chk i_chk (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .wait_request_n_i(wait_request_n_i), .cpu_done_o(cpu_done_o),
	.ext_master_req_n_i(ext_master_req_n_i), .ext_master_grant_n_o(ext_master_grant_n_o),
	.address_strobe_n_o(address_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
	.area_select_n_o(area_select_n_o), .address_o(address_o));

/* verif/ext_bus_wait_and_arbiter_tb.sv */
`timescale 1ns/1ps
module ext_bus_wait_and_arbiter_tb
	import ext_bus_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cpu_req_i = 1'b0, cpu_write_i = 1'b0, cpu_seq_i = 1'b0, cpu_pair_first_i = 1'b0;
	logic cpu_internal_op_i = 1'b0, cpu_power_down_i = 1'b0, stall = 1'b0;
	logic ext_master_req_n_i = 1'b1;
	logic [1:0] cpu_lanes_i = 2'h0;
	logic [2:0] cpu_area_i = 3'h0;
	logic [ADDR_W-1:0] cpu_addr_i = '0, address_o;
	logic [DATA_W-1:0] cpu_wdata_i = '0, cpu_rdata_o, data_in_i, data_out_o;
	logic [WAIT_FIELD_W-1:0] program_wait_count_i = 4'h0;
	logic cpu_done_o, wait_request_n_i, ext_master_grant_n_o, address_strobe_n_o;
	logic read_strobe_n_o, upper_write_strobe_n_o, lower_write_strobe_n_o, data_oe_o;
	logic [AREA_COUNT-1:0] area_select_n_o;
	int errors = 0, check_count = 0, rises = 0, n, r0, dn;
	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge read_strobe_n_o) rises++;
	ext_bus_wait_and_arbiter i_dut (.ref_clk_i, .reset_i, .cpu_req_i, .cpu_write_i, .cpu_seq_i,
		.cpu_pair_first_i, .cpu_lanes_i, .cpu_area_i, .cpu_addr_i, .cpu_wdata_i,
		.program_wait_count_i, .cpu_internal_op_i, .cpu_power_down_i, .cpu_done_o,
		.cpu_rdata_o, .wait_request_n_i, .ext_master_req_n_i, .data_in_i,
		.ext_master_grant_n_o, .address_strobe_n_o, .read_strobe_n_o, .upper_write_strobe_n_o,
		.lower_write_strobe_n_o, .area_select_n_o, .address_o, .data_out_o, .data_oe_o);
	ext_mem_model i_mem (.ref_clk_i, .read_strobe_n_i(read_strobe_n_o), .address_i(address_o),
		.stall_i(stall), .wait_request_n_o(wait_request_n_i), .data_o(data_in_i));
	task automatic report_and_stop();
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic tick();
		@(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Counts cycles up to the next done pulse; a pulse already showing is not counted.
	task automatic wait_done();
		n = 0;
		do begin
			tick();
			n++;
		end while (cpu_done_o !== 1'b1 && n < 40);
		if (n >= 40) begin
			errors++;
			report_and_stop();
		end
	endtask : wait_done
	task automatic acc(input logic [3:0] f, input logic w);
		program_wait_count_i = f;
		cpu_write_i = w;
		cpu_area_i = f[2:0];
		cpu_lanes_i = {f[1], 1'b1};
		cpu_addr_i = {20'h12340, f};
		cpu_wdata_i = {12'hC3A, f};
		cpu_req_i = 1'b1;
		tick();
		// The access is taken at this edge, so strobes and selects already show it.
		chk("ctl", {address_strobe_n_o, read_strobe_n_o, data_oe_o}, {1'b0, w, w});
		chk("wr", {upper_write_strobe_n_o, lower_write_strobe_n_o}, {!(w && f[1]), !w});
		chk("sel", area_select_n_o, {~(8'h01 << f[2:0])});
		chk("addr_out", address_o, cpu_addr_i);
		if (w) chk("wdata_out", data_out_o, cpu_wdata_i);
		wait_done();
		cpu_req_i = 1'b0;
		chk("latency", n + 1, f + 4);
		if (!w) chk("rdata", cpu_rdata_o, cpu_addr_i[15:0] ^ 16'hA5C3);
		// Lets any access taken at the final state drain before the next step.
		repeat (26) tick();
	endtask : acc
	task automatic seq_reads();
		cpu_seq_i = 1'b1;
		cpu_write_i = 1'b0;
		program_wait_count_i = 4'h0;
		cpu_req_i = 1'b1;
		r0 = rises;
		wait_done();
		cpu_req_i = 1'b0;
		wait_done();
		chk("rd_rises", rises - r0, 1);
		cpu_seq_i = 1'b0;
		repeat (26) tick();
	endtask : seq_reads
	task automatic stall_read();
		int d;
		d = 0;
		stall = 1'b1;
		program_wait_count_i = 4'h1;
		cpu_req_i = 1'b1;
		repeat (8) begin
			tick();
			d += cpu_done_o;
		end
		stall = 1'b0;
		chk("stalled_done", d, 0);
		wait_done();
		cpu_req_i = 1'b0;
		chk("resume", n, 2);
		repeat (26) tick();
	endtask : stall_read
	// Waits for the grant to reach a level, counting the done pulses seen on the way.
	task automatic wait_grant(input logic lvl);
		n = 0;
		dn = 0;
		while (ext_master_grant_n_o !== lvl && n < 30) begin
			tick();
			cpu_pair_first_i = 1'b0;
			dn += cpu_done_o;
			n++;
		end
		if (n >= 30) begin
			errors++;
			report_and_stop();
		end
	endtask : wait_grant
	// The processor keeps asking throughout, so the request lands on a running access unless power-down is set.
	task automatic ext(input logic io, input logic pd, input logic pr);
		cpu_write_i = 1'b0;
		program_wait_count_i = 4'h0;
		cpu_internal_op_i = io;
		cpu_power_down_i = pd;
		cpu_pair_first_i = pr;
		cpu_req_i = 1'b1;
		ext_master_req_n_i = 1'b0;
		wait_grant(1'b0);
		chk("grant_wait", n >= 3, 1);
		// A running access ends first, a paired one runs both halves, power-down starts none.
		chk("dones_before", dn, pd ? 0 : (pr ? 2 : 1));
		chk("idle_pins", {address_strobe_n_o, read_strobe_n_o, area_select_n_o}, 10'h3FF);
		dn = 0;
		repeat (5) begin
			tick();
			dn += cpu_done_o;
		end
		chk("held", {ext_master_grant_n_o, dn[3:0]}, 5'h00);
		ext_master_req_n_i = 1'b1;
		cpu_internal_op_i = 1'b0;
		cpu_power_down_i = 1'b0;
		wait_grant(1'b1);
		chk("grant_back", n, 2);
		wait_done();
		cpu_req_i = 1'b0;
		chk("regain", n, 4);
		repeat (26) tick();
	endtask : ext
	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1;
		reset_i = 1'b0;
		for (int f = 0; f < 16; f++) acc(f[3:0], f[0]);
		seq_reads();
		stall_read();
		ext(1'b0, 1'b0, 1'b0);
		ext(1'b1, 1'b0, 1'b0);
		ext(1'b0, 1'b1, 1'b0);
		ext(1'b0, 1'b0, 1'b1);
		report_and_stop();
	end
endmodule : ext_bus_wait_and_arbiter_tb
